// >>> src/cil_lookup.sv
module cil_lookup
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Received command from the bus decoder.
  input wire logic i_cmd_valid,
  input wire logic [15:0] i_cmd_word,
  input wire logic i_cmd_broadcast,
  input wire logic i_cmd_error,
  // Response decision.
  output logic o_resp_valid,
  output logic o_respond,
  output logic o_msg_error,
  output logic o_status_update,
  output logic [5:0] o_data_words,
  output logic o_table_fetch,
  // Readiness.
  output logic o_ready
);

  logic [15:0] tbl_reg [cil_pkg::TABLE_WORDS];
  logic [1:0] cfg_reg;
  logic [31:0] prdata_reg;
  logic resp_valid_reg;
  logic respond_reg;
  logic msg_error_reg;
  logic status_update_reg;
  logic [5:0] data_words_reg;
  logic table_fetch_reg;
  logic last_illegal_reg;
  logic last_ignored_reg;
  logic [15:0] last_cmd_reg;

  logic clr_busy;
  logic [7:0] clr_addr;
  logic ready;
  logic [7:0] word_index;
  logic [3:0] bit_sel;
  logic is_mode;
  logic undef_mode;
  logic bcast_tx_sa;
  logic [5:0] cmd_data_words;

  logic [9:0] reg_idx;
  logic hit_table;
  logic hit_config;
  logic hit_status;
  logic mapped;
  logic apb_setup;
  logic apb_write;
  logic start_exec;
  logic umc_invalid;
  logic cmd_take;
  logic cmd_ignored;
  logic fetched_bit;
  logic tbl_any_set;

  cil_ram_clear cil_ram_clear_inst
  (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .o_busy(clr_busy),
    .o_addr(clr_addr),
    .o_ready(ready)
  );

  cil_cmd_decode cil_cmd_decode_inst
  (
    .i_cmd_word(i_cmd_word),
    .i_broadcast(i_cmd_broadcast),
    .o_word_index(word_index),
    .o_bit_sel(bit_sel),
    .o_is_mode(is_mode),
    .o_undef_mode(undef_mode),
    .o_bcast_tx_sa(bcast_tx_sa),
    .o_data_words(cmd_data_words)
  );

  // Bus decode; the table sits at byte addresses 0x400..0x7FC.
  assign reg_idx = i_paddr[11:2];
  assign hit_table = (reg_idx >= cil_pkg::IDX_TABLE_FIRST) && (reg_idx <= cil_pkg::IDX_TABLE_LAST);
  assign hit_config = (reg_idx == cil_pkg::IDX_CONFIG);
  assign hit_status = (reg_idx == cil_pkg::IDX_STATUS);
  assign mapped = hit_table || hit_config || hit_status;
  assign apb_setup = i_psel && !i_penable;
  assign apb_write = i_psel && i_penable && i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;

  assign start_exec = cfg_reg[cil_pkg::CFG_START_EXECUTION_BIT];
  assign umc_invalid = cfg_reg[cil_pkg::CFG_UNDEFINED_MODE_INVALID_BIT];
  assign cmd_take = i_cmd_valid && ready && start_exec;
  // Anything invalid before lookup is dropped silently and never touches the table.
  assign cmd_ignored = i_cmd_error || bcast_tx_sa || (undef_mode && umc_invalid);
  assign fetched_bit = tbl_reg[word_index][bit_sel];

  // Table storage; the self-test sweep owns the write port until it finishes.
  always_ff @(posedge i_sys_clk)
  begin
    if (clr_busy)
    begin
      tbl_reg[clr_addr] <= 16'h0000;
    end
    else if (apb_write && hit_table)
    begin
      tbl_reg[reg_idx[7:0]] <= i_pwdata[15:0];
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      cfg_reg <= cil_pkg::CFG_RESET;
    end
    else if (apb_write && hit_config)
    begin
      cfg_reg <= i_pwdata[1:0];
    end
  end

  // Read data is captured in the setup cycle so that it leaves a flip-flop.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      prdata_reg <= 32'h0000_0000;
    end
    else if (apb_setup)
    begin
      prdata_reg <= 32'h0000_0000;
      if (hit_table)
      begin
        prdata_reg[15:0] <= tbl_reg[reg_idx[7:0]];
      end
      else if (hit_config)
      begin
        prdata_reg[1:0] <= cfg_reg;
      end
      else if (hit_status)
      begin
        prdata_reg[cil_pkg::STAT_READY_BIT] <= ready;
        prdata_reg[cil_pkg::STAT_LAST_ILLEGAL_BIT] <= last_illegal_reg;
        prdata_reg[cil_pkg::STAT_LAST_IGNORED_BIT] <= last_ignored_reg;
        prdata_reg[cil_pkg::STAT_LAST_CMD_LSB +: 16] <= last_cmd_reg;
      end
    end
  end

  // Decision on each accepted command, one cycle after it is offered.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      resp_valid_reg <= 1'b0;
      respond_reg <= 1'b0;
      msg_error_reg <= 1'b0;
      status_update_reg <= 1'b0;
      data_words_reg <= 6'h00;
      table_fetch_reg <= 1'b0;
    end
    else
    begin
      resp_valid_reg <= cmd_take;
      respond_reg <= cmd_take && !cmd_ignored;
      msg_error_reg <= cmd_take && !cmd_ignored && fetched_bit;
      status_update_reg <= cmd_take && !cmd_ignored;
      table_fetch_reg <= cmd_take && !cmd_ignored;
      if (cmd_take && !cmd_ignored && !fetched_bit)
      begin
        data_words_reg <= cmd_data_words;
      end
      else
      begin
        data_words_reg <= 6'h00;
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      last_illegal_reg <= 1'b0;
      last_ignored_reg <= 1'b0;
      last_cmd_reg <= 16'h0000;
    end
    else if (cmd_take)
    begin
      last_illegal_reg <= !cmd_ignored && fetched_bit;
      last_ignored_reg <= cmd_ignored;
      last_cmd_reg <= i_cmd_word;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_resp_valid = resp_valid_reg;
  assign o_respond = respond_reg;
  assign o_msg_error = msg_error_reg;
  assign o_status_update = status_update_reg;
  assign o_data_words = data_words_reg;
  assign o_table_fetch = table_fetch_reg;
  assign o_ready = ready;

  // Any set word at the moment ready rises means the sweep skipped an address.
  always_comb
  begin
    tbl_any_set = 1'b0;
    for (int i = 0; i < cil_pkg::TABLE_WORDS; i++)
    begin
      tbl_any_set = tbl_any_set || (tbl_reg[i] != 16'h0000);
    end
  end

  sequence s_take_checked;
    cmd_take && !cmd_ignored;
  endsequence

  sequence s_take_illegal;
    s_take_checked ##0 fetched_bit;
  endsequence

  sequence s_take_legal;
    s_take_checked ##0 !fetched_bit;
  endsequence

  a_ready_after_clear: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $rose(ready) |-> $past(clr_busy) && clr_addr == 8'h00)
    else $error("ready rose without a finished clear sweep");

  a_table_zero_ready: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $rose(ready) |-> !tbl_any_set && tbl_reg[8'hFF] == 16'h0000 && tbl_reg[8'h00] == 16'h0000)
    else $error("table not clear when ready rose");

  a_wait_for_start: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_cmd_valid && !start_exec) |=> !o_resp_valid && !o_table_fetch)
    else $error("command processed before start of execution");

  a_legal_in_form: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    s_take_legal |=> o_respond && !o_msg_error && o_status_update && (o_data_words != 6'h00 || $past(is_mode)))
    else $error("legal command did not get an in-form answer");

  a_illegal_status_only: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    s_take_illegal |=> o_respond && o_msg_error && o_status_update && o_data_words == 6'h00)
    else $error("illegal command answer is wrong");

  a_bcast_tx_silent: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (cmd_take && bcast_tx_sa) |=> o_resp_valid && !o_respond && !o_status_update && !o_table_fetch)
    else $error("broadcast transmit subaddress command answered");

  a_undef_mode_silent: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (cmd_take && undef_mode && umc_invalid) |=> !o_respond && !o_status_update)
    else $error("undefined mode command answered while invalid");

  a_error_no_fetch: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (cmd_take && i_cmd_error) |=> !o_table_fetch && !o_respond)
    else $error("errored command fetched the table");

  a_addr_formula: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    cmd_take |-> {2'b00, word_index} == 10'h100 - 10'h100 + (i_cmd_broadcast ? 10'h000 : 10'h080) +
      (i_cmd_word[10] ? 10'h040 : 10'h000) + {4'h0, i_cmd_word[9:5], 1'b0} + {9'h000, i_cmd_word[4]})
    else $error("table word address formed wrongly");

  a_full_count_bit0: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (s_take_legal ##0 (!is_mode && i_cmd_word[4:0] == 5'h00)) |=> o_data_words == 6'h20)
    else $error("zero count did not mean 32 words");

  a_ready_holds: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    ready |=> ready)
    else $error("ready fell without a reset");

  a_table_write_lands: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (apb_write && hit_table && !clr_busy) |=> tbl_reg[$past(reg_idx[7:0])] == $past(i_pwdata[15:0]))
    else $error("table write did not land");

  a_config_write: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (apb_write && hit_config) |=> cfg_reg == $past(i_pwdata[1:0]))
    else $error("configuration write did not land");

  a_fetch_answered: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_table_fetch |-> o_resp_valid && o_respond && o_status_update)
    else $error("table fetch without an answer");

  a_mode_data_count: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (s_take_legal ##0 is_mode) |=> o_data_words == {5'h00, $past(i_cmd_word[4])})
    else $error("mode command data count wrong");

  a_illegal_logged: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    s_take_illegal |=> last_illegal_reg && !last_ignored_reg)
    else $error("illegal command not logged in status");

  a_split_index: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    cmd_take |-> word_index[7] == !i_cmd_broadcast && word_index[6] == i_cmd_word[10])
    else $error("broadcast or direction not kept apart in the index");

  a_count_odd_word: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (cmd_take && !is_mode && i_cmd_word[4]) |-> word_index[0] && {1'b0, bit_sel} == i_cmd_word[4:0] - 5'h10)
    else $error("count above 15 mapped to the wrong bit");

  a_mode_even_word: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (cmd_take && is_mode && !i_cmd_word[4]) |-> !word_index[0] && {1'b0, bit_sel} == i_cmd_word[4:0])
    else $error("low mode code mapped to the wrong bit");

  a_mode_odd_word: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (cmd_take && is_mode && i_cmd_word[4]) |-> word_index[0] && {1'b0, bit_sel} == i_cmd_word[4:0] - 5'h10)
    else $error("high mode code mapped to the wrong bit");

  a_tx_sa1_word: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (cmd_take && !i_cmd_broadcast && i_cmd_word[10] && i_cmd_word[9:5] == 5'h01) |->
      word_index == {7'h61, i_cmd_word[4]})
    else $error("transmit subaddress one used the wrong table word");

endmodule

// >>> common/cil_pkg.sv
package cil_pkg;

  // Register word indices; the byte address on the bus is four times the index.
  localparam logic [9:0] IDX_CONFIG = 10'h001;
  localparam logic [9:0] IDX_STATUS = 10'h002;
  localparam logic [9:0] IDX_TABLE_FIRST = 10'h100;
  localparam logic [9:0] IDX_TABLE_LAST = 10'h1FF;
  localparam int TABLE_WORDS = 256;

  // Configuration register fields.
  localparam int CFG_START_EXECUTION_BIT = 0;
  localparam int CFG_UNDEFINED_MODE_INVALID_BIT = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;

  // Status register fields.
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_LAST_ILLEGAL_BIT = 1;
  localparam int STAT_LAST_IGNORED_BIT = 2;
  localparam int STAT_LAST_CMD_LSB = 16;

  // Command word fields.
  localparam int CMD_TR_BIT = 10;
  localparam int CMD_SUBADDRESS_LSB = 5;
  localparam logic [4:0] SUBADDRESS_MODE_LOW = 5'h00;
  localparam logic [4:0] SUBADDRESS_MODE_HIGH = 5'h1F;
  localparam logic [5:0] FULL_WORD_COUNT = 6'h20;

  // Self-test clears one table word per cycle.
  localparam logic [7:0] CLEAR_LAST_ADDR = 8'hFF;

endpackage

// >>> src/cil_cmd_decode.sv
// Splits a received command word into the table address, the bit to fetch and its class.
module cil_cmd_decode
(
  // Received command.
  input wire logic [15:0] i_cmd_word,
  input wire logic i_broadcast,
  // Lookup index and classification.
  output logic [7:0] o_word_index,
  output logic [3:0] o_bit_sel,
  output logic o_is_mode,
  output logic o_undef_mode,
  output logic o_bcast_tx_sa,
  output logic [5:0] o_data_words
);

  logic tr;
  logic [4:0] subaddress_field;
  logic [4:0] low_field;

  assign tr = i_cmd_word[cil_pkg::CMD_TR_BIT];
  assign subaddress_field = i_cmd_word[cil_pkg::CMD_SUBADDRESS_LSB +: 5];
  assign low_field = i_cmd_word[4:0];
  assign o_is_mode = (subaddress_field == cil_pkg::SUBADDRESS_MODE_LOW) ||
                     (subaddress_field == cil_pkg::SUBADDRESS_MODE_HIGH);
  assign o_word_index = {~i_broadcast, tr, subaddress_field, low_field[4]};
  // Low four bits pick the bit in both halves; count 0 lands on bit 0 as 32 words.
  assign o_bit_sel = low_field[3:0];
  assign o_bcast_tx_sa = i_broadcast && tr && !o_is_mode;
  assign o_undef_mode = o_is_mode &&
                        ((!tr && (!low_field[4] || low_field == 5'h10 || low_field == 5'h12 ||
                                  low_field == 5'h13)) ||
                         (tr && (low_field == 5'h11 || low_field == 5'h14 || low_field == 5'h15)));

  always_comb
  begin
    if (o_is_mode)
    begin
      o_data_words = {5'h00, low_field[4]};
    end
    else if (low_field == 5'h00)
    begin
      o_data_words = cil_pkg::FULL_WORD_COUNT;
    end
    else
    begin
      o_data_words = {1'b0, low_field};
    end
  end

endmodule

// >>> src/cil_ram_clear.sv
// Post-reset self-test sweep that zeroes every table word, then declares ready.
module cil_ram_clear
(
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Clear port toward the table.
  output logic o_busy,
  output logic [7:0] o_addr,
  output logic o_ready
);

  typedef enum logic [0:0] {CLR_RUN, CLR_DONE} cil_clear_e;

  cil_clear_e state_reg;
  logic [7:0] addr_reg;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      state_reg <= CLR_RUN;
    end
    else
    begin
      case (state_reg)
        CLR_RUN:
        begin
          if (addr_reg == cil_pkg::CLEAR_LAST_ADDR)
          begin
            state_reg <= CLR_DONE;
          end
        end
        CLR_DONE:
        begin
          state_reg <= CLR_DONE;
        end
        default:
        begin
          state_reg <= CLR_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      addr_reg <= 8'h00;
    end
    else if (state_reg == CLR_RUN)
    begin
      addr_reg <= addr_reg + 8'h01;
    end
  end

  assign o_busy = (state_reg == CLR_RUN);
  assign o_addr = addr_reg;
  assign o_ready = (state_reg == CLR_DONE);

endmodule

// >>> sim/cil_bc_model.sv
module cil_bc_model
(
  // Clock.
  input wire logic i_sys_clk,
  // Command toward the lookup.
  output logic o_cmd_valid,
  output logic [15:0] o_cmd_word,
  output logic o_cmd_broadcast,
  output logic o_cmd_error
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd_word = 16'h0000;
    o_cmd_broadcast = 1'b0;
    o_cmd_error = 1'b0;
  end

  // Between commands the lines carry the inverse of the last value, so a stale word never looks fresh.
  task automatic send(input logic [15:0] w, input logic b, input logic e);
    @(posedge i_sys_clk);
    o_cmd_valid <= 1'b1;
    o_cmd_word <= w;
    o_cmd_broadcast <= b;
    o_cmd_error <= e;
    @(posedge i_sys_clk);
    o_cmd_valid <= 1'b0;
    o_cmd_word <= ~w;
    o_cmd_broadcast <= ~b;
    o_cmd_error <= ~e;
  endtask
endmodule

// >>> sim/command_illegalization_lookup_tb_top.sv
module command_illegalization_lookup_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [4:0] LEGAL = 5'h1B;
  localparam logic [4:0] ILL = 5'h1F;
  localparam logic [4:0] SIL = 5'h10;
  localparam logic [4:0] NONE = 5'h00;

  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, cmd_valid, cmd_bc, cmd_err;
  logic [15:0] cmd_word;
  logic resp_valid, respond, msg_error, status_update, table_fetch, ready;
  logic [5:0] data_words;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int checks_done = 0;

  always #2.5 i_sys_clk = ~i_sys_clk;

  cil_bc_model cil_bc_model_inst (.i_sys_clk(i_sys_clk), .o_cmd_valid(cmd_valid), .o_cmd_word(cmd_word),
    .o_cmd_broadcast(cmd_bc), .o_cmd_error(cmd_err));

  cil_lookup #(.ADDR_W(12)) cil_lookup_inst (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_cmd_valid(cmd_valid), .i_cmd_word(cmd_word),
    .i_cmd_broadcast(cmd_bc), .i_cmd_error(cmd_err), .o_resp_valid(resp_valid), .o_respond(respond),
    .o_msg_error(msg_error), .o_status_update(status_update), .o_data_words(data_words),
    .o_table_fetch(table_fetch), .o_ready(ready));

  task automatic tally_and_finish();
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge i_sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do
    begin
      @(posedge i_sys_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, idx, 32'h0000_0000);
    chk("read data", exp, rd);
    chk("slave error", {31'h0, exp_err}, {31'h0, err});
  endtask

  // Flags are resp_valid, respond, msg_error, status_update, table_fetch.
  task automatic cmd(input logic t, input logic [4:0] sa, input logic [4:0] cnt, input logic b,
                     input logic e, input logic [4:0] fl, input logic [5:0] words);
    cil_bc_model_inst.send({5'h01, t, sa, cnt}, b, e);
    #1;
    chk("response", {21'h0, fl, words},
        {21'h0, resp_valid, respond, msg_error, status_update, table_fetch, data_words});
  endtask

  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    n_errors++;
    tally_and_finish();
  end

  initial
  begin
    repeat (2) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    for (int i = 0; i < 400 && ready !== 1'b1; i++)
      @(posedge i_sys_clk);
    chk("ready", 32'h1, {31'h0, ready});
    rdchk(cil_pkg::IDX_STATUS, 32'h1, 1'b0) ;
    rdchk(10'h100, 32'h0, 1'b0);
    rdchk(10'h1C2, 32'h0, 1'b0);
    rdchk(10'h1FF, 32'h0, 1'b0);
    rdchk(10'h003, 32'h0, 1'b1);
    cmd(1'b1, 5'h01, 5'h04, 1'b0, 1'b0, NONE, 6'h00);
    apb(1'b1, cil_pkg::IDX_CONFIG, 32'h0000_0001);
    // The host fills the table before commands arrive.
    apb(1'b1, 10'h1C2, 32'h0000_FF0F);
    apb(1'b1, 10'h1C3, 32'h0000_FFFF);
    apb(1'b1, 10'h1FF, 32'h0000_0001);
    apb(1'b1, 10'h1C1, 32'h0000_0001);
    apb(1'b1, 10'h104, 32'h0000_0008);
    rdchk(10'h1C2, 32'h0000_FF0F, 1'b0);
    for (int c = 1; c <= 32; c++)
      if (c >= 4 && c <= 7)
        cmd(1'b1, 5'h01, c[4:0], 1'b0, 1'b0, LEGAL, c[5:0]);
      else
        cmd(1'b1, 5'h01, c[4:0], 1'b0, 1'b0, ILL, 6'h00);
    cmd(1'b1, 5'h00, 5'h10, 1'b0, 1'b0, ILL, 6'h00);
    cmd(1'b1, 5'h1F, 5'h10, 1'b0, 1'b0, ILL, 6'h00);
    cmd(1'b1, 5'h1F, 5'h11, 1'b0, 1'b0, LEGAL, 6'h01);
    cmd(1'b1, 5'h00, 5'h02, 1'b0, 1'b0, LEGAL, 6'h00);
    cmd(1'b0, 5'h02, 5'h03, 1'b1, 1'b0, ILL, 6'h00);
    cmd(1'b0, 5'h02, 5'h03, 1'b0, 1'b0, LEGAL, 6'h03);
    cmd(1'b1, 5'h02, 5'h03, 1'b0, 1'b0, LEGAL, 6'h03);
    cmd(1'b1, 5'h05, 5'h03, 1'b1, 1'b0, SIL, 6'h00);
    cmd(1'b0, 5'h01, 5'h04, 1'b0, 1'b1, SIL, 6'h00);
    cmd(1'b0, 5'h00, 5'h01, 1'b0, 1'b0, LEGAL, 6'h00);
    apb(1'b1, cil_pkg::IDX_CONFIG, 32'h0000_0003);
    rdchk(cil_pkg::IDX_CONFIG, 32'h0000_0003, 1'b0);
    cmd(1'b0, 5'h00, 5'h01, 1'b0, 1'b0, SIL, 6'h00);
    rdchk(cil_pkg::IDX_STATUS, 32'h0801_0005, 1'b0);
    cmd(1'b1, 5'h1F, 5'h11, 1'b0, 1'b0, SIL, 6'h00);
    cmd(1'b1, 5'h1F, 5'h12, 1'b0, 1'b0, LEGAL, 6'h01);
    cmd(1'b1, 5'h01, 5'h1F, 1'b0, 1'b0, ILL, 6'h00);
    rdchk(cil_pkg::IDX_STATUS, 32'h0C3F_0003, 1'b0);
    cmd(1'b1, 5'h01, 5'h07, 1'b0, 1'b0, LEGAL, 6'h07);
    rdchk(cil_pkg::IDX_STATUS, 32'h0C27_0001, 1'b0);
    tally_and_finish();
  end
endmodule
